// ===== src/lvdc_pkg.sv
package lvdc_pkg;
  localparam logic [15:0] LVDC_CTRL_ADDR = 16'hffbe;
  localparam logic [15:0] LVDC_LEVEL_ADDR = 16'hffbf;
  localparam logic [15:0] LVDC_CAUSE_ADDR = 16'hffac;
  localparam logic [15:0] LVDC_IRQF_ADDR = 16'hffe0;
  localparam logic [15:0] LVDC_IRQM_ADDR = 16'hffe4;
  localparam int LVDC_ON_BIT = 7;
  localparam int LVDC_REF_BIT = 4;
  localparam int LVDC_MODE_BIT = 1;
  localparam int LVDC_FLAG_BIT = 0;
  localparam int LVDC_IRQ_BIT = 0;
  localparam int LVDC_CAUSE_BIT = 0;
  localparam logic [7:0] LVDC_CTRL_RST = 8'h00;
  localparam logic [2:0] LVDC_LEVEL_RST = 3'h0;
  localparam logic [2:0] LVDC_LEVEL_BAD = 3'h7;
  localparam logic [2:0] LVDC_LEVEL_POC_MIN = 3'h4;
  localparam logic LVDC_MASK_RST = 1'b1;
endpackage

// ===== src/lvdc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module lvdc_sync import lvdc_pkg::*; (
  mclk,
  rst_n,
  async_in,
  sync_out
);
  input wire logic mclk;
  input wire logic rst_n;
  input wire logic async_in;
  output logic sync_out;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } lvdc_sync_s;

  lvdc_sync_s st_r;
  lvdc_sync_s st_nxt;

  always_comb begin
    st_nxt.stage1 = async_in;
    st_nxt.stage2 = st_r.stage1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stage2;
endmodule
`default_nettype wire

// ===== src/lvdc_top.sv
`timescale 1ns/10ps
`default_nettype none
module lvdc_top import lvdc_pkg::*; (
  mclk,
  rst_n,
  bus_addr,
  bus_wr,
  bus_rd,
  bus_wdata,
  bus_rdata,
  cmp_below,
  poc_used,
  poc_high_thresh,
  poc_reset,
  other_reset,
  stop_mode,
  halt_mode,
  cpu_on_subclk,
  x1_stopped,
  detect_reset,
  detect_irq,
  reference_en,
  comparator_en,
  level_code,
  regulator_en
);
  input wire logic mclk;
  input wire logic rst_n;
  input wire logic [15:0] bus_addr;
  input wire logic bus_wr;
  input wire logic bus_rd;
  input wire logic [7:0] bus_wdata;
  output logic [7:0] bus_rdata;
  input wire logic cmp_below;
  input wire logic poc_used;
  input wire logic poc_high_thresh;
  input wire logic poc_reset;
  input wire logic other_reset;
  input wire logic stop_mode;
  input wire logic halt_mode;
  input wire logic cpu_on_subclk;
  input wire logic x1_stopped;
  output logic detect_reset;
  output logic detect_irq;
  output logic reference_en;
  output logic comparator_en;
  output logic [2:0] level_code;
  output logic regulator_en;

  typedef struct packed {
    logic detector_enable;
    logic reference_enable;
    logic reset_mode_select;
    logic [2:0] level;
    logic below_level_flag;
    logic irq_src_prev;
    logic detect_irq_request;
    logic detect_irq_mask;
    logic detect_reset_cause;
    logic rst_out;
    logic irq_out;
    logic ref_out;
    logic cmp_out;
    logic reg_out;
    logic [7:0] rdata;
  } lvdc_state_s;

  lvdc_state_s st_r;
  lvdc_state_s st_nxt;
  logic below_sync;

  lvdc_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(cmp_below),
    .sync_out(below_sync)
  );

  function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  logic poc_prio;
  logic irq_src;
  logic in_reset;

  always_comb begin
    st_nxt = st_r;
    // power-on-clear owns levels 4..6 when its threshold is the high one
    poc_prio = poc_high_thresh && (st_r.level >= LVDC_LEVEL_POC_MIN);
    irq_src = st_r.detector_enable && !st_r.reset_mode_select && st_r.below_level_flag;
    in_reset = st_r.rst_out || poc_reset || other_reset;
    st_nxt.below_level_flag = below_sync && st_r.detector_enable;
    st_nxt.irq_src_prev = irq_src;
    // reset only while below the level, never merely on mode selection
    st_nxt.rst_out = st_r.detector_enable && st_r.reset_mode_select
                     && st_r.below_level_flag && !poc_prio;
    if (bus_wr && hit(bus_addr, LVDC_CTRL_ADDR)) begin
      st_nxt.detector_enable = bus_wdata[LVDC_ON_BIT];
      st_nxt.reference_enable = bus_wdata[LVDC_REF_BIT];
      st_nxt.reset_mode_select = bus_wdata[LVDC_MODE_BIT];
    end
    if (bus_wr && hit(bus_addr, LVDC_LEVEL_ADDR) && bus_wdata[2:0] != LVDC_LEVEL_BAD) begin
      st_nxt.level = bus_wdata[2:0];
    end
    if (bus_wr && hit(bus_addr, LVDC_IRQM_ADDR)) begin
      st_nxt.detect_irq_mask = bus_wdata[LVDC_IRQ_BIT];
    end
    if (bus_wr && hit(bus_addr, LVDC_IRQF_ADDR) && !bus_wdata[LVDC_IRQ_BIT]) begin
      st_nxt.detect_irq_request = 1'b0;
    end
    if (irq_src && !st_r.irq_src_prev) begin
      st_nxt.detect_irq_request = 1'b1;
    end
    if (bus_rd && hit(bus_addr, LVDC_CAUSE_ADDR)) begin
      st_nxt.detect_reset_cause = 1'b0;
    end
    if (poc_reset) begin
      st_nxt.detect_reset_cause = 1'b0;
    end else if (st_r.rst_out) begin
      st_nxt.detect_reset_cause = 1'b1;
    end
    // other resets clear control unless a detector reset is active; a detector reset leaves it alone
    if ((poc_reset || other_reset) && !st_r.rst_out) begin
      st_nxt.detector_enable = 1'b0;
      st_nxt.reference_enable = 1'b0;
      st_nxt.reset_mode_select = 1'b0;
    end
    st_nxt.ref_out = st_r.reference_enable || poc_used;
    st_nxt.cmp_out = st_r.detector_enable;
    st_nxt.irq_out = st_r.detect_irq_request && !st_r.detect_irq_mask;
    st_nxt.reg_out = !(in_reset || stop_mode
                       || (halt_mode && cpu_on_subclk && x1_stopped));
    st_nxt.rdata = 8'h00;
    if (bus_rd) begin
      if (hit(bus_addr, LVDC_CTRL_ADDR)) begin
        st_nxt.rdata[LVDC_ON_BIT] = st_r.detector_enable;
        st_nxt.rdata[LVDC_REF_BIT] = st_r.reference_enable;
        st_nxt.rdata[LVDC_MODE_BIT] = st_r.reset_mode_select;
        st_nxt.rdata[LVDC_FLAG_BIT] = st_r.below_level_flag;
      end else if (hit(bus_addr, LVDC_LEVEL_ADDR)) begin
        st_nxt.rdata[2:0] = st_r.level;
      end else if (hit(bus_addr, LVDC_CAUSE_ADDR)) begin
        st_nxt.rdata[LVDC_CAUSE_BIT] = st_r.detect_reset_cause;
      end else if (hit(bus_addr, LVDC_IRQF_ADDR)) begin
        st_nxt.rdata[LVDC_IRQ_BIT] = st_r.detect_irq_request;
      end else if (hit(bus_addr, LVDC_IRQM_ADDR)) begin
        st_nxt.rdata[LVDC_IRQ_BIT] = st_r.detect_irq_mask;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.level <= LVDC_LEVEL_RST;
      st_r.detect_irq_mask <= LVDC_MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus_rdata = st_r.rdata;
  assign detect_reset = st_r.rst_out;
  assign detect_irq = st_r.irq_out;
  assign reference_en = st_r.ref_out;
  assign comparator_en = st_r.cmp_out;
  assign level_code = st_r.level;
  assign regulator_en = st_r.reg_out;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_LEVEL_WRITE: assert property (
    bus_wr && hit(bus_addr, LVDC_LEVEL_ADDR) |=>
      level_code == ((bus_wdata[2:0] == LVDC_LEVEL_BAD) ? $past(level_code) : $past(bus_wdata[2:0])))
    else $error("level select not updated as written");
  AST_RESET_BELOW: assert property (
    st_r.detector_enable && st_r.reset_mode_select && st_r.below_level_flag && !poc_prio
      |=> detect_reset)
    else $error("no internal reset while below level in reset mode");
  AST_NO_RESET_ABOVE: assert property (
    !st_r.below_level_flag |=> !detect_reset)
    else $error("internal reset while supply above level");
  AST_POC_PRIO: assert property (
    poc_prio |=> !detect_reset)
    else $error("detector reset despite power-on-clear priority");
  AST_FLAG_OFF: assert property (
    !st_r.detector_enable |=> !st_r.below_level_flag)
    else $error("flag set while detection disabled");
  AST_SYNC_PATH: assert property (
    st_r.detector_enable [*4] ##0 $rose(cmp_below) ##1 st_r.detector_enable
      |-> !st_r.below_level_flag || $past(st_r.below_level_flag))
    else $error("comparator reached flag without synchronising");
  AST_IRQ_SET: assert property (
    irq_src && !st_r.irq_src_prev |=> st_r.detect_irq_request ##1 (detect_irq == !st_r.detect_irq_mask))
    else $error("interrupt request not raised by flag");
  AST_IRQ_CLEAR: assert property (
    bus_wr && hit(bus_addr, LVDC_IRQF_ADDR) && !bus_wdata[0] && !(irq_src && !st_r.irq_src_prev)
      |=> !st_r.detect_irq_request)
    else $error("request flag not cleared by writing zero");
  AST_CAUSE_SET: assert property (
    detect_reset && !poc_reset |=> st_r.detect_reset_cause)
    else $error("reset cause not recorded");
  AST_CTRL_CLEAR: assert property (
    other_reset && !detect_reset |=> !st_r.detector_enable && !st_r.reset_mode_select)
    else $error("control bits survive a non-detector reset");
  AST_CTRL_KEEP: assert property (
    detect_reset && !(bus_wr && hit(bus_addr, LVDC_CTRL_ADDR)) |=> $stable(st_r.detector_enable))
    else $error("detector reset altered control bits");
  AST_REGULATOR_OFF: assert property (
    stop_mode || (halt_mode && cpu_on_subclk && x1_stopped) || other_reset |=> !regulator_en)
    else $error("regulator left on in reset or low power");
  AST_REF_POC: assert property (
    poc_used |=> reference_en)
    else $error("reference off while power-on-clear in use");

  COV_DETECT_RESET: cover property (st_r.reset_mode_select ##1 $rose(detect_reset));
  COV_DETECT_IRQ: cover property ($rose(detect_irq));
  COV_CAUSE_READ: cover property (st_r.detect_reset_cause ##1 bus_rd && hit(bus_addr, LVDC_CAUSE_ADDR));
  COV_REG_HALT: cover property (halt_mode && cpu_on_subclk && x1_stopped ##1 !regulator_en);
endmodule
`default_nettype wire

// ===== verification/lvdc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lvdc_top_tb import lvdc_pkg::*;;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] bus_addr;
  logic bus_wr, bus_rd;
  logic [7:0] bus_wdata, bus_rdata, d;
  logic cmp_below, poc_used, poc_high_thresh, poc_reset, other_reset;
  logic stop_mode, halt_mode, cpu_on_subclk, x1_stopped;
  logic detect_reset, detect_irq, reference_en, comparator_en, regulator_en;
  logic [2:0] level_code;
  int n_errors = 0;
  int n_tests = 0;
  always #2 mclk = ~mclk;
  lvdc_top uut (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .cmp_below(cmp_below), .poc_used(poc_used),
    .poc_high_thresh(poc_high_thresh), .poc_reset(poc_reset), .other_reset(other_reset),
    .stop_mode(stop_mode), .halt_mode(halt_mode), .cpu_on_subclk(cpu_on_subclk), .x1_stopped(x1_stopped),
    .detect_reset(detect_reset), .detect_irq(detect_irq), .reference_en(reference_en),
    .comparator_en(comparator_en), .level_code(level_code), .regulator_en(regulator_en));
  task final_report;
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    v = bus_rdata;
  endtask
  task t_reset;
    rd(LVDC_LEVEL_ADDR, d);
    chk(d, 8'h00);
    rd(LVDC_CTRL_ADDR, d);
    chk(d, 8'h00);
    rd(LVDC_IRQM_ADDR, d);
    chk({7'h00, d[0]}, 8'h01);
    chk({7'h00, regulator_en}, 8'h01);
  endtask
  task t_level;
    wr(LVDC_LEVEL_ADDR, 8'h03);
    rd(LVDC_LEVEL_ADDR, d);
    chk(d, 8'h03);
    wr(LVDC_LEVEL_ADDR, 8'h07);
    w(1);
    chk({5'h00, level_code}, 8'h03);
    wr(LVDC_LEVEL_ADDR, 8'h06);
    w(1);
    chk({5'h00, level_code}, 8'h06);
  endtask
  task t_irq;
    wr(LVDC_CTRL_ADDR, 8'h90);
    @(posedge mclk) cmp_below <= 1'b1;
    w(6);
    chk({6'h00, comparator_en, reference_en}, 8'h03);
    rd(LVDC_CTRL_ADDR, d);
    chk(d, 8'h91);
    chk({6'h00, detect_irq, detect_reset}, 8'h00);
    rd(LVDC_IRQF_ADDR, d);
    chk({7'h00, d[0]}, 8'h01);
    wr(LVDC_IRQM_ADDR, 8'h00);
    w(2);
    chk({7'h00, detect_irq}, 8'h01);
    @(posedge mclk) cmp_below <= 1'b0;
    w(6);
    rd(LVDC_CTRL_ADDR, d);
    chk(d, 8'h90);
    wr(LVDC_IRQF_ADDR, 8'h00);
    w(2);
    chk({7'h00, detect_irq}, 8'h00);
    @(posedge mclk) cmp_below <= 1'b1;
    w(6);
    chk({7'h00, detect_irq}, 8'h01);
    wr(LVDC_CTRL_ADDR, 8'h10);
    wr(LVDC_CTRL_ADDR, 8'h00);
    w(2);
    rd(LVDC_CTRL_ADDR, d);
    chk(d, 8'h00);
    wr(LVDC_IRQM_ADDR, 8'h01);
    @(posedge mclk) cmp_below <= 1'b0;
  endtask
  task t_rst_mode;
    wr(LVDC_CTRL_ADDR, 8'h90);
    w(6);
    rd(LVDC_CTRL_ADDR, d);
    chk(d, 8'h90);
    wr(LVDC_CTRL_ADDR, 8'h92);
    w(6);
    chk({7'h00, detect_reset}, 8'h00);
    rd(LVDC_CAUSE_ADDR, d);
    chk({7'h00, d[0]}, 8'h00);
    @(posedge mclk) cmp_below <= 1'b1;
    w(6);
    chk({7'h00, detect_reset}, 8'h01);
    rd(LVDC_CAUSE_ADDR, d);
    chk({7'h00, d[0]}, 8'h01);
    @(posedge mclk) other_reset <= 1'b1;
    @(posedge mclk) other_reset <= 1'b0;
    rd(LVDC_CTRL_ADDR, d);
    chk(d, 8'h93);
    wr(LVDC_CTRL_ADDR, 8'h00);
    cmp_below <= 1'b0;
    w(6);
    chk({7'h00, detect_reset}, 8'h00);
    wr(LVDC_CTRL_ADDR, 8'h90);
    @(posedge mclk) other_reset <= 1'b1;
    @(posedge mclk) other_reset <= 1'b0;
    rd(LVDC_CTRL_ADDR, d);
    chk(d, 8'h00);
  endtask
  task t_poc;
    poc_high_thresh <= 1'b1;
    wr(LVDC_LEVEL_ADDR, 8'h04);
    wr(LVDC_CTRL_ADDR, 8'h90);
    w(6);
    wr(LVDC_CTRL_ADDR, 8'h92);
    @(posedge mclk) cmp_below <= 1'b1;
    w(6);
    chk({7'h00, detect_reset}, 8'h00);
    wr(LVDC_CTRL_ADDR, 8'h00);
    cmp_below <= 1'b0;
    poc_high_thresh <= 1'b0;
    poc_used <= 1'b1;
    w(2);
    chk({7'h00, reference_en}, 8'h01);
    wr(LVDC_CTRL_ADDR, 8'h90);
    @(posedge mclk) poc_reset <= 1'b1;
    @(posedge mclk) poc_reset <= 1'b0;
    rd(LVDC_CTRL_ADDR, d);
    chk(d, 8'h00);
    @(posedge mclk) poc_used <= 1'b0;
  endtask
  task t_power;
    @(posedge mclk) stop_mode <= 1'b1;
    w(2);
    chk({7'h00, regulator_en}, 8'h00);
    @(posedge mclk) stop_mode <= 1'b0;
    halt_mode <= 1'b1;
    w(2);
    chk({7'h00, regulator_en}, 8'h01);
    @(posedge mclk) cpu_on_subclk <= 1'b1;
    x1_stopped <= 1'b1;
    w(2);
    chk({7'h00, regulator_en}, 8'h00);
    @(posedge mclk) {halt_mode, cpu_on_subclk, x1_stopped} <= 3'h0;
    rst_n <= 1'b0;
    w(2);
    chk({4'h0, regulator_en, level_code}, 8'h00);
    @(posedge mclk) rst_n <= 1'b1;
    rd(LVDC_IRQM_ADDR, d);
    chk(d, 8'h01);
    chk({7'h00, regulator_en}, 8'h01);
  endtask
  initial begin
    {bus_addr, bus_wr, bus_rd, bus_wdata} = '0;
    {cmp_below, poc_used, poc_high_thresh, poc_reset, other_reset} = '0;
    {stop_mode, halt_mode, cpu_on_subclk, x1_stopped} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
    t_level;
    t_irq;
    t_rst_mode;
    t_poc;
    t_power;
    final_report;
  end
  initial begin
    #20000;
    n_errors++;
    final_report;
  end
endmodule
`default_nettype wire
